// *** pmfc_pkg.sv ***
// Purpose: Shared constants for the timing-message filter configuration block
// Assumes: 16-bit register port, 100 MHz mclk, 25 MHz reference derived
// Notes: Offsets are byte addresses on the register port
package pmfc_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 16;
  localparam logic [11:0] OFS_RATE_LO = 12'h610;
  localparam logic [11:0] OFS_RATE_HI = 12'h612;
  localparam logic [11:0] OFS_DUR_LO = 12'h614;
  localparam logic [11:0] OFS_DUR_HI = 12'h616;
  localparam logic [11:0] OFS_CFG1 = 12'h620;
  localparam logic [11:0] OFS_CFG2 = 12'h622;

  // Rate-step high word fields
  localparam int unsigned RATE_DIR_BIT = 15;
  localparam int unsigned TEMP_START_BIT = 14;
  localparam int unsigned RATE_HI_W = 14;
  localparam int unsigned STEP_W = 30;

  // First message config word fields
  localparam int unsigned CFG1_PTP_EN = 6;
  localparam int unsigned CFG1_RAW_EN = 5;
  localparam int unsigned CFG1_IPV4_EN = 4;
  localparam int unsigned CFG1_IPV6_EN = 3;
  localparam int unsigned CFG1_P2P = 2;
  localparam int unsigned CFG1_MASTER = 1;
  localparam int unsigned CFG1_ONE_STEP = 0;
  localparam logic [15:0] CFG1_RST = 16'h0059;
  localparam logic [15:0] CFG1_MASK = 16'h00ff;

  // Second message config word fields
  localparam int unsigned CFG2_UNICAST = 12;
  localparam int unsigned CFG2_ALT_MASTER = 11;
  localparam int unsigned CFG2_ALL_HIPRI = 10;
  localparam int unsigned CFG2_SYNC_ASSOC = 9;
  localparam int unsigned CFG2_DLY_ASSOC = 8;
  localparam int unsigned CFG2_PDLY_ASSOC = 7;
  localparam logic [15:0] CFG2_RST = 16'h0400;
  localparam logic [15:0] CFG2_MASK = 16'h1f80;

  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // Message types
  localparam logic [3:0] MSG_SYNC = 4'h0;
  localparam logic [3:0] MSG_DLY_REQ = 4'h1;
  localparam logic [3:0] MSG_PDLY_REQ = 4'h2;
  localparam logic [3:0] MSG_PDLY_RESP = 4'h3;
  localparam logic [3:0] MSG_FOLLOW_UP = 4'h8;
  localparam logic [3:0] MSG_DLY_RESP = 4'h9;
  localparam logic [3:0] MSG_PDLY_RFU = 4'ha;
  localparam logic [3:0] MSG_EVENT_LIMIT = 4'h4;

  localparam logic [15:0] UDP_EVENT_PORT = 16'h013f;
  localparam logic [15:0] UDP_GENERAL_PORT = 16'h0140;

  typedef enum logic [1:0] {
    ENC_RAW = 2'b00,
    ENC_IPV4 = 2'b01,
    ENC_IPV6 = 2'b10,
    ENC_OTHER = 2'b11
  } pmfc_encap_e;

  typedef enum logic {
    ADJ_IDLE = 1'b0,
    ADJ_RUN = 1'b1
  } pmfc_adj_e;

  // Association key: domain 8, sequence id 16, source port identity 80
  localparam int unsigned KEY_W = 104;
  localparam int unsigned TRK_N = 3;
  localparam int unsigned TRK_SYNC = 0;
  localparam int unsigned TRK_DLY = 1;
  localparam int unsigned TRK_PDLY = 2;

  // Timing
  localparam int unsigned MCLK_PERIOD_NS = 10;
  localparam int unsigned REF_PERIOD_NS = 40;
  localparam int unsigned REF_DIV = REF_PERIOD_NS / MCLK_PERIOD_NS;
  localparam int unsigned DIV_W = 2;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(REF_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = 2'h0;
  localparam int unsigned INC_W = 40;
  localparam int unsigned FRAC_W = 32;
  localparam logic [INC_W-1:0] NOMINAL_INC =
    INC_W'(REF_PERIOD_NS) << FRAC_W;
  localparam logic [31:0] DUR_ZERO = 32'h0000_0000;
  localparam logic [31:0] DUR_ONE = 32'h0000_0001;
endpackage

// *** pmfc_assoc_tracker.sv ***
// Purpose: Remembers the last request key per kind and flags matching replies
// Assumes: Keys arrive on the same clock, one frame per cycle at most
// Notes: A store and a compare in the same cycle compare the old key
`timescale 1ns/1ps
module pmfc_assoc_tracker
  import pmfc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [TRK_N-1:0] store_en,
  input wire logic [KEY_W-1:0] key,
  output logic [TRK_N-1:0] match
);
  genvar gi;
  generate
    for (gi = 0; gi < TRK_N; gi++) begin : g_entry
      logic [KEY_W-1:0] key_reg;
      logic [KEY_W-1:0] key_next;
      logic valid_reg;
      logic valid_next;
      always_comb begin
        key_next = key_reg;
        valid_next = valid_reg;
        if (store_en[gi]) begin
          key_next = key;
          valid_next = 1'b1;
        end
      end
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          key_reg <= '0;
          valid_reg <= 1'b0;
        end else if (clk_en) begin
          key_reg <= key_next;
          valid_reg <= valid_next;
        end
      end
      // Never matches before a request has been seen
      assign match[gi] = valid_reg && (key_reg == key);
    end
  endgenerate
endmodule

// *** pmfc_core.sv ***
// Purpose: Timing-message config registers, frame verdicts, temp rate adjust
// Assumes: Frame descriptors come from a parser on mclk; 16-bit reg port
// Notes: Reference tick is mclk divided to 25 MHz; clk_en freezes all state
`timescale 1ns/1ps
module pmfc_core
  import pmfc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  output logic [INC_W-1:0] inc_value,
  output logic inc_valid,
  output logic adj_active,
  input wire logic frame_valid,
  input wire pmfc_encap_e frame_encap,
  input wire logic [3:0] frame_msg_type,
  input wire logic frame_reserved_addr,
  input wire logic [15:0] frame_udp_dport,
  input wire logic frame_from_port1,
  input wire logic frame_from_master,
  input wire logic frame_same_domain,
  input wire logic host_master_attached,
  input wire logic [KEY_W-1:0] frame_key,
  output logic verdict_valid,
  output logic verdict_ptp,
  output logic verdict_to_host,
  output logic verdict_drop,
  output logic verdict_hi_prio,
  output logic verdict_table_lookup,
  output logic tc_p2p,
  output logic oc_master,
  output logic one_step
);
  logic [15:0] rate_lo_reg, rate_lo_next;
  logic [15:0] rate_hi_reg, rate_hi_next;
  logic [15:0] dur_lo_reg, dur_lo_next;
  logic [15:0] dur_hi_reg, dur_hi_next;
  logic [15:0] cfg1_reg, cfg1_next;
  logic [15:0] cfg2_reg, cfg2_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  pmfc_adj_e adj_reg, adj_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [DIV_W-1:0] div_reg, div_next;
  logic [INC_W-1:0] inc_reg, inc_next;
  logic incv_reg, incv_next;
  logic ref_tick;
  logic start_wr;
  logic adj_end;
  logic [STEP_W-1:0] step;
  logic step_nonzero;

  assign ref_tick = (div_reg == DIV_LAST);
  assign step = {rate_hi_reg[RATE_HI_W-1:0], rate_lo_reg};
  assign step_nonzero = (step != '0);
  assign start_wr = reg_we && (reg_addr == OFS_RATE_HI)
    && reg_wdata[TEMP_START_BIT];
  assign adj_end = (adj_reg == ADJ_RUN) && ref_tick && (cnt_reg <= DUR_ONE);

  // Register file and read port
  always_comb begin
    rate_lo_next = rate_lo_reg;
    rate_hi_next = rate_hi_reg;
    dur_lo_next = dur_lo_reg;
    dur_hi_next = dur_hi_reg;
    cfg1_next = cfg1_reg;
    cfg2_next = cfg2_reg;
    rvalid_next = reg_re;
    rdata_next = rdata_reg;
    // Hardware self-clear; a start write in the same cycle wins below
    if (adj_end) begin
      rate_hi_next[TEMP_START_BIT] = 1'b0;
    end
    if (reg_we) begin
      unique case (reg_addr)
        OFS_RATE_LO: rate_lo_next = reg_wdata;
        OFS_RATE_HI: rate_hi_next = reg_wdata;
        OFS_DUR_LO: dur_lo_next = reg_wdata;
        OFS_DUR_HI: dur_hi_next = reg_wdata;
        OFS_CFG1: cfg1_next = reg_wdata & CFG1_MASK;
        OFS_CFG2: cfg2_next = reg_wdata & CFG2_MASK;
        default: ;
      endcase
    end
    if (reg_re) begin
      unique case (reg_addr)
        OFS_RATE_LO: rdata_next = rate_lo_reg;
        OFS_RATE_HI: rdata_next = rate_hi_reg;
        OFS_DUR_LO: rdata_next = dur_lo_reg;
        OFS_DUR_HI: rdata_next = dur_hi_reg;
        OFS_CFG1: rdata_next = cfg1_reg;
        OFS_CFG2: rdata_next = cfg2_reg;
        default: rdata_next = WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rate_lo_reg <= WORD_ZERO;
      rate_hi_reg <= WORD_ZERO;
      dur_lo_reg <= WORD_ZERO;
      dur_hi_reg <= WORD_ZERO;
      cfg1_reg <= CFG1_RST;
      cfg2_reg <= CFG2_RST;
      rdata_reg <= WORD_ZERO;
      rvalid_reg <= 1'b0;
    end else if (clk_en) begin
      rate_lo_reg <= rate_lo_next;
      rate_hi_reg <= rate_hi_next;
      dur_lo_reg <= dur_lo_next;
      dur_hi_reg <= dur_hi_next;
      cfg1_reg <= cfg1_next;
      cfg2_reg <= cfg2_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // Temporary adjustment and per-reference-cycle increment
  always_comb begin
    div_next = ref_tick ? DIV_ZERO : div_reg + 2'h1;
    adj_next = adj_reg;
    cnt_next = cnt_reg;
    incv_next = ref_tick;
    inc_next = inc_reg;
    if (ref_tick && adj_reg == ADJ_RUN) begin
      cnt_next = cnt_reg - DUR_ONE;
    end
    if (adj_end) begin
      adj_next = ADJ_IDLE;
    end
    if (reg_we && reg_addr == OFS_RATE_HI
        && !reg_wdata[TEMP_START_BIT]) begin
      adj_next = ADJ_IDLE;
    end
    if (start_wr) begin
      adj_next = ADJ_RUN;
      cnt_next = {dur_hi_reg, dur_lo_reg};
    end
    if (ref_tick) begin
      if (adj_reg == ADJ_RUN && step_nonzero) begin
        inc_next = rate_hi_reg[RATE_DIR_BIT]
          ? NOMINAL_INC - INC_W'(step)
          : NOMINAL_INC + INC_W'(step);
      end else begin
        inc_next = NOMINAL_INC;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= DIV_ZERO;
      adj_reg <= ADJ_IDLE;
      cnt_reg <= DUR_ZERO;
      inc_reg <= NOMINAL_INC;
      incv_reg <= 1'b0;
    end else if (clk_en) begin
      div_reg <= div_next;
      adj_reg <= adj_next;
      cnt_reg <= cnt_next;
      inc_reg <= inc_next;
      incv_reg <= incv_next;
    end
  end

  // Frame classification
  logic [TRK_N-1:0] store_en;
  logic [TRK_N-1:0] match;
  logic enc_ok, udp_enc, unicast_ok, is_ptp;
  logic m_sync, m_fu, m_dreq, m_dresp, m_presp;
  logic v_ptp, v_host, v_drop, v_hipri, v_lookup;
  logic vv_reg, vptp_reg, vhost_reg, vdrop_reg, vhp_reg, vlk_reg;

  assign m_sync = frame_msg_type == MSG_SYNC;
  assign m_fu = frame_msg_type == MSG_FOLLOW_UP;
  assign m_dreq = frame_msg_type == MSG_DLY_REQ;
  assign m_dresp = frame_msg_type == MSG_DLY_RESP;
  assign m_presp = (frame_msg_type == MSG_PDLY_RESP)
    || (frame_msg_type == MSG_PDLY_RFU);
  assign store_en[TRK_SYNC] = frame_valid && is_ptp && m_sync;
  assign store_en[TRK_DLY] = frame_valid && is_ptp && m_dreq;
  assign store_en[TRK_PDLY] = frame_valid && is_ptp
    && (frame_msg_type == MSG_PDLY_REQ);

  pmfc_assoc_tracker u_tracker (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .store_en(store_en),
    .key(frame_key),
    .match(match)
  );

  always_comb begin
    udp_enc = (frame_encap == ENC_IPV4) || (frame_encap == ENC_IPV6);
    enc_ok = ((frame_encap == ENC_RAW) && cfg1_reg[CFG1_RAW_EN])
      || ((frame_encap == ENC_IPV4) && cfg1_reg[CFG1_IPV4_EN])
      || ((frame_encap == ENC_IPV6) && cfg1_reg[CFG1_IPV6_EN]);
    unicast_ok = udp_enc && cfg2_reg[CFG2_UNICAST] && !frame_reserved_addr
      && (frame_udp_dport == UDP_EVENT_PORT
      || frame_udp_dport == UDP_GENERAL_PORT);
    is_ptp = cfg1_reg[CFG1_PTP_EN] && enc_ok
      && (frame_reserved_addr || (frame_encap == ENC_RAW) || unicast_ok);
    v_ptp = is_ptp;
    v_lookup = is_ptp && unicast_ok;
    v_hipri = is_ptp && (cfg2_reg[CFG2_ALL_HIPRI]
      || frame_msg_type < MSG_EVENT_LIMIT);
    v_host = is_ptp && !v_lookup;
    v_drop = 1'b0;
    if (is_ptp && frame_same_domain) begin
      if (cfg2_reg[CFG2_ALT_MASTER]) begin
        if (frame_from_port1 && frame_from_master
            && (m_sync || m_fu || m_dreq || m_dresp)) begin
          v_host = 1'b1;
        end
      end else if (host_master_attached) begin
        if (m_sync) begin
          v_drop = 1'b1;
        end else if (m_dreq && frame_from_port1 && frame_from_master) begin
          v_host = 1'b1;
        end
      end
    end
    if (is_ptp && cfg2_reg[CFG2_SYNC_ASSOC] && m_fu && !match[TRK_SYNC]) begin
      v_drop = 1'b1;
    end
    if (is_ptp && cfg2_reg[CFG2_DLY_ASSOC] && m_dresp && !match[TRK_DLY]) begin
      v_drop = 1'b1;
    end
    if (is_ptp && cfg2_reg[CFG2_PDLY_ASSOC] && !frame_from_port1 && m_presp
        && !match[TRK_PDLY]) begin
      v_drop = 1'b1;
    end
    if (v_drop) begin
      v_host = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      vv_reg <= 1'b0;
      vptp_reg <= 1'b0;
      vhost_reg <= 1'b0;
      vdrop_reg <= 1'b0;
      vhp_reg <= 1'b0;
      vlk_reg <= 1'b0;
    end else if (clk_en) begin
      vv_reg <= frame_valid;
      vptp_reg <= frame_valid && v_ptp;
      vhost_reg <= frame_valid && v_host;
      vdrop_reg <= frame_valid && v_drop;
      vhp_reg <= frame_valid && v_hipri;
      vlk_reg <= frame_valid && v_lookup;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign inc_value = inc_reg;
  assign inc_valid = incv_reg;
  assign adj_active = rate_hi_reg[TEMP_START_BIT];
  assign verdict_valid = vv_reg;
  assign verdict_ptp = vptp_reg;
  assign verdict_to_host = vhost_reg;
  assign verdict_drop = vdrop_reg;
  assign verdict_hi_prio = vhp_reg;
  assign verdict_table_lookup = vlk_reg;
  assign tc_p2p = cfg1_reg[CFG1_P2P];
  assign oc_master = cfg1_reg[CFG1_MASTER];
  assign one_step = cfg1_reg[CFG1_ONE_STEP];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_start;
    clk_en && start_wr;
  endsequence
  sequence s_run_held;
    adj_reg == ADJ_RUN;
  endsequence

  a_start_loads: assert property (s_start |=> s_run_held
    and (cnt_reg == $past({dur_hi_reg, dur_lo_reg})))
    else $error("Start did not load duration");
  a_start_sets_bit: assert property (s_start |=> adj_active)
    else $error("Start bit not set after write");
  a_end_clears: assert property (clk_en && adj_end && !reg_we
    |=> !adj_active && adj_reg == ADJ_IDLE)
    else $error("Adjustment did not self-clear");
  a_count_step: assert property (ref_tick && adj_reg == ADJ_RUN
    && clk_en && !adj_end && !reg_we |=> cnt_reg == $past(cnt_reg) - DUR_ONE)
    else $error("Duration counter did not step");
  a_zero_step_nom: assert property (ref_tick && !step_nonzero
    && clk_en |=> inc_value == NOMINAL_INC)
    else $error("Zero step altered increment");
  a_inc_sign: assert property (clk_en && ref_tick
    && adj_reg == ADJ_RUN && step_nonzero && !rate_hi_reg[RATE_DIR_BIT]
    |=> inc_value == NOMINAL_INC + INC_W'($past(step)))
    else $error("Increment sign wrong");
  a_tick_period: assert property (clk_en && inc_valid
    |=> !inc_valid)
    else $error("Reference tick too frequent");
  a_ptp_disabled: assert property (clk_en && frame_valid
    && !cfg1_reg[CFG1_PTP_EN] |=> !verdict_ptp)
    else $error("Frame classified while disabled");
  a_dresp_drop: assert property (clk_en && frame_valid
    && is_ptp && m_dresp && cfg2_reg[CFG2_DLY_ASSOC] && !match[TRK_DLY]
    |=> verdict_drop && !verdict_to_host)
    else $error("Unmatched delay response passed");
  a_sync_drop: assert property (clk_en && frame_valid
    && is_ptp && m_sync && frame_same_domain && !cfg2_reg[CFG2_ALT_MASTER]
    && host_master_attached |=> verdict_drop)
    else $error("Sync not dropped without alternate master");
endmodule

// *** pmfc_remote_clock.sv ***
// Purpose: Far-side model presenting frame descriptors from remote clocks
// Assumes: Testbench raises send for one mclk cycle per frame
// Notes: Idle descriptor lines show inverted values, never stale ones
`timescale 1ns/1ps
module pmfc_remote_clock
  import pmfc_pkg::*;
(
  input wire logic send,
  input wire logic [3:0] typ,
  input wire pmfc_encap_e enc,
  input wire logic [3:0] flags,
  input wire logic [7:0] key_lo,
  output logic frame_valid,
  output pmfc_encap_e frame_encap,
  output logic [3:0] frame_msg_type,
  output logic frame_reserved_addr,
  output logic [15:0] frame_udp_dport,
  output logic frame_from_port1,
  output logic frame_from_master,
  output logic frame_same_domain,
  output logic [KEY_W-1:0] frame_key
);
  logic [KEY_W-1:0] key;
  assign key = {{(KEY_W-8){1'b0}}, key_lo};
  assign frame_valid = send;
  // Outside a frame nothing is held, so garbage must not look valid
  assign frame_encap = send ? enc : pmfc_encap_e'(~enc);
  assign frame_msg_type = send ? typ : ~typ;
  assign frame_reserved_addr = send ? flags[3] : ~flags[3];
  assign frame_udp_dport = send ? UDP_EVENT_PORT : ~UDP_EVENT_PORT;
  assign frame_from_port1 = send ? flags[2] : ~flags[2];
  assign frame_from_master = send ? flags[1] : ~flags[1];
  assign frame_same_domain = send ? flags[0] : ~flags[0];
  assign frame_key = send ? key : ~key;
endmodule

// *** testbench.sv ***
// Purpose: Register, rate-adjust and classifier checks of the core
// Assumes: Inputs change 1 ns after each rising mclk edge
// Notes: Verdict masks skip outputs left open for a frame kind
`timescale 1ns/1ps
module testbench
  import pmfc_pkg::*;
;
  logic mclk, reset_n, clk_en, reg_we, reg_re, host_master_attached;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic reg_rvalid, inc_valid, adj_active, send;
  logic [INC_W-1:0] inc_value;
  logic [3:0] typ, flags, f_type;
  logic [7:0] key_lo;
  pmfc_encap_e enc, f_encap;
  logic f_valid, f_rsv, f_p1, f_mst, f_same;
  logic [15:0] f_dport;
  logic [KEY_W-1:0] f_key;
  logic v_valid, v_ptp, v_host, v_drop, v_hi, v_lut, tc_p2p, oc_master;
  logic one_step;
  int num_errors = 0;
  int n_compared = 0;

  pmfc_core pmfc_core_i (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .inc_value(inc_value), .inc_valid(inc_valid), .adj_active(adj_active),
    .frame_valid(f_valid), .frame_encap(f_encap), .frame_msg_type(f_type),
    .frame_reserved_addr(f_rsv), .frame_udp_dport(f_dport),
    .frame_from_port1(f_p1), .frame_from_master(f_mst),
    .frame_same_domain(f_same), .host_master_attached(host_master_attached),
    .frame_key(f_key), .verdict_valid(v_valid), .verdict_ptp(v_ptp),
    .verdict_to_host(v_host), .verdict_drop(v_drop), .verdict_hi_prio(v_hi),
    .verdict_table_lookup(v_lut), .tc_p2p(tc_p2p), .oc_master(oc_master),
    .one_step(one_step));

  pmfc_remote_clock pmfc_remote_clock_i (.send(send), .typ(typ), .enc(enc),
    .flags(flags), .key_lo(key_lo), .frame_valid(f_valid),
    .frame_encap(f_encap), .frame_msg_type(f_type),
    .frame_reserved_addr(f_rsv), .frame_udp_dport(f_dport),
    .frame_from_port1(f_p1), .frame_from_master(f_mst),
    .frame_same_domain(f_same), .frame_key(f_key));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [INC_W-1:0] seen,
                       input logic [INC_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Leading idle edge keeps a strobe from toggling twice in one time step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(posedge mclk) #1;
    reg_we = 1'b0;
  endtask

  // Read answer stands one cycle only, so it is sampled right after the edge
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge mclk) #1;
    reg_addr = a;
    reg_re = 1'b1;
    @(posedge mclk) #1;
    reg_re = 1'b0;
    check(reg_rvalid, 1'b1);
    check(reg_rdata, e);
  endtask

  // Expected verdict bits: ptp, to_host, drop, hi_prio, table_lookup
  task automatic fr(input logic [3:0] t, input pmfc_encap_e e,
                    input logic [3:0] f, input logic [7:0] k,
                    input logic [4:0] exp, input logic [4:0] msk);
    @(posedge mclk) #1;
    typ = t;
    enc = e;
    flags = f;
    key_lo = k;
    send = 1'b1;
    @(posedge mclk) #1;
    send = 1'b0;
    check(v_valid, 1'b1);
    check({v_ptp, v_host, v_drop, v_hi, v_lut} & msk, exp & msk);
  endtask

  // Counts ticks that carry the expected increment over fifteen ticks
  task automatic adj(input logic [15:0] hi, input logic [INC_W-1:0] e,
                     input int n);
    int cnt;
    cnt = 0;
    wr(OFS_RATE_HI, hi);
    check(adj_active, 1'b1);
    for (int i = 0; i < 60; i++) begin
      @(posedge mclk) #1;
      if (inc_valid === 1'b1 && inc_value === e) cnt++;
    end
    check(cnt, n);
    check(adj_active, 1'b0);
    rd(OFS_RATE_HI, hi & 16'hbfff);
  endtask

  initial begin
    {reg_we, reg_re, send, host_master_attached} = 4'h0;
    {reg_addr, reg_wdata, typ, flags, key_lo} = '0;
    enc = ENC_IPV4;
    clk_en = 1'b1;
    reset_n = 1'b0;
    repeat (10) @(posedge mclk);
    #1 reset_n = 1'b1;
    rd(OFS_DUR_LO, 16'h0000);
    rd(OFS_DUR_HI, 16'h0000);
    rd(OFS_CFG1, 16'h0059);
    rd(OFS_CFG2, 16'h0400);
    check({tc_p2p, oc_master, one_step}, 3'h1);
    wr(OFS_CFG1, 16'hfffe);
    check({tc_p2p, oc_master, one_step}, 3'h6);
    rd(OFS_CFG1, 16'h00fe);
    wr(OFS_CFG2, 16'hffff);
    rd(OFS_CFG2, 16'h1f80);
    rd(12'h618, 16'h0000);
    clk_en = 1'b0;
    wr(OFS_CFG1, 16'h0000);
    clk_en = 1'b1;
    rd(OFS_CFG1, 16'h00fe);
    wr(OFS_DUR_HI, 16'ha5c3);
    rd(OFS_DUR_HI, 16'ha5c3);
    wr(OFS_DUR_HI, 16'h0000);
    wr(OFS_DUR_LO, 16'h0003);
    wr(OFS_RATE_LO, 16'h0001);
    adj(16'h4000, NOMINAL_INC + 40'h1, 3);
    adj(16'hc000, NOMINAL_INC - 40'h1, 3);
    wr(OFS_RATE_LO, 16'h0000);
    adj(16'h4000, NOMINAL_INC, 15);
    // Classifier: raw off, IPv4 and IPv6 on, event to top queue
    wr(OFS_CFG1, 16'h0059);
    wr(OFS_CFG2, 16'h0000);
    fr(MSG_DLY_REQ, ENC_RAW, 4'h8, 8'h01, 5'h00, 5'h10);
    fr(MSG_DLY_REQ, ENC_IPV4, 4'h8, 8'h01, 5'h1a, 5'h1f);
    fr(MSG_DLY_REQ, ENC_IPV6, 4'h8, 8'h01, 5'h10, 5'h10);
    fr(MSG_FOLLOW_UP, ENC_IPV4, 4'h8, 8'h01, 5'h10, 5'h12);
    fr(MSG_DLY_REQ, ENC_IPV4, 4'h0, 8'h01, 5'h00, 5'h10);
    wr(OFS_CFG1, 16'h0019);
    fr(MSG_DLY_REQ, ENC_IPV4, 4'h8, 8'h01, 5'h00, 5'h10);
    wr(OFS_CFG1, 16'h0079);
    fr(MSG_DLY_REQ, ENC_RAW, 4'h8, 8'h01, 5'h10, 5'h10);
    wr(OFS_CFG2, 16'h1780);
    fr(MSG_DLY_REQ, ENC_IPV4, 4'h0, 8'h01, 5'h11, 5'h11);
    fr(MSG_FOLLOW_UP, ENC_IPV4, 4'h8, 8'h01, 5'h12, 5'h12);
    fr(MSG_DLY_RESP, ENC_IPV4, 4'h8, 8'h22, 5'h14, 5'h1d);
    fr(MSG_DLY_RESP, ENC_IPV4, 4'h8, 8'h01, 5'h18, 5'h1d);
    fr(MSG_PDLY_RESP, ENC_IPV4, 4'h8, 8'h33, 5'h14, 5'h1d);
    fr(MSG_PDLY_REQ, ENC_IPV4, 4'h8, 8'h33, 5'h10, 5'h10);
    fr(MSG_PDLY_RFU, ENC_IPV4, 4'h8, 8'h33, 5'h18, 5'h1d);
    fr(MSG_SYNC, ENC_IPV4, 4'h8, 8'h44, 5'h10, 5'h10);
    fr(MSG_FOLLOW_UP, ENC_IPV4, 4'h8, 8'h45, 5'h14, 5'h1d);
    fr(MSG_FOLLOW_UP, ENC_IPV4, 4'h8, 8'h44, 5'h18, 5'h1d);
    // Alternate master off then on, host port behind a master
    host_master_attached = 1'b1;
    wr(OFS_CFG2, 16'h0000);
    fr(MSG_SYNC, ENC_IPV4, 4'hf, 8'h50, 5'h14, 5'h1d);
    fr(MSG_DLY_REQ, ENC_IPV4, 4'hf, 8'h51, 5'h18, 5'h1c);
    wr(OFS_CFG2, 16'h0800);
    fr(MSG_SYNC, ENC_IPV4, 4'hf, 8'h52, 5'h18, 5'h1c);
    fr(MSG_DLY_RESP, ENC_IPV4, 4'hf, 8'h53, 5'h18, 5'h1c);
    tally_and_finish();
  end

  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
endmodule
